// ===== verilog/idcp_defs.vh
`ifndef IDCP_DEFS_VH
`define IDCP_DEFS_VH
// ----------------------------------------------------------------
// mode field, cycle counts, opcode upper-byte patterns
// ----------------------------------------------------------------
`define IDCP_MODE_PROTECTED   3'b000
`define IDCP_CYC_ONE          2'd1
`define IDCP_CYC_TWO          2'd2
`define IDCP_CYC_THREE        2'd3
`define IDCP_OP_TBLWT_HI      6'b1010_11
`define IDCP_OP_TABLE_LATCH_READ_OP_HI       6'b1010_00
`define IDCP_OP_TABLE_LATCH_WRITE_OP_HI       6'b1010_01
`define IDCP_OP_TBLRD_HI      6'b1010_10
`define IDCP_OP_TSTZ          8'h33
`define IDCP_OP_XORF_HI       7'b0000_110
`define IDCP_OP_BCLR_HI       5'b1000_1
`define IDCP_OP_BSET_HI       5'b1000_0
`define IDCP_OP_SKCLR_HI      5'b1001_1
`define IDCP_OP_SKSET_HI      5'b1001_0
`define IDCP_OP_BTOG_HI       5'b0011_1
`define IDCP_OP_ADDL          8'hb1
`define IDCP_OP_SUBL          8'hb2
`define IDCP_OP_IORL          8'hb3
`define IDCP_OP_XORL          8'hb4
`define IDCP_OP_ANDL          8'hb5
`define IDCP_OP_RETL          8'hb6
`define IDCP_OP_LONG_CALL_OP         8'hb7
`define IDCP_OP_MOVB          8'hb8
`define IDCP_OP_MOVR_HI       7'b1011_101
`define IDCP_OP_MOVL          8'hb0
`define IDCP_OP_MULL          8'hbc
`define IDCP_OP_GOTO_HI       3'b110
`define IDCP_OP_CALL_HI       3'b111
`define IDCP_OP_RETURN        16'h0002
`define IDCP_OP_SLEEP         16'h0003
`define IDCP_OP_WATCHDOG_CLEAR_OP        16'h0004
`define IDCP_OP_INTERRUPT_RETURN_OP        16'h0005
`define IDCP_PCL_ADDR         8'h02
`endif

// ===== verilog/idcp_alu.v
`timescale 1ns/1ps
`include "idcp_defs.vh"
// ----------------------------------------------------------------
// literal arithmetic and logic unit
// ----------------------------------------------------------------
module idcp_alu
(
    input  wire [2:0]  op_sel,
    input  wire [7:0]  a_in,
    input  wire [7:0]  b_in,
    output reg  [7:0]  res,
    output reg         c_out,
    output reg         dc_out,
    output reg         ov_out
);
    reg [8:0] sum;
    reg [4:0] nib;
    // 0 add, 1 sub b-a, 2 and, 3 or, 4 xor, others pass b
    always @*
    begin
        sum    = 9'h000;
        nib    = 5'h00;
        res    = b_in;
        c_out  = 1'b0;
        dc_out = 1'b0;
        ov_out = 1'b0;
        case (op_sel)
            3'd0:
            begin
                sum    = {1'b0, a_in} + {1'b0, b_in};
                nib    = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
                res    = sum[7:0];
                c_out  = sum[8];
                dc_out = nib[4];
                ov_out = (a_in[7] == b_in[7]) && (sum[7] != a_in[7]);
            end
            3'd1:
            begin
                sum    = {1'b0, b_in} + {1'b0, ~a_in} + 9'h001;
                nib    = {1'b0, b_in[3:0]} + {1'b0, ~a_in[3:0]} + 5'h01;
                res    = sum[7:0];
                c_out  = sum[8];
                dc_out = nib[4];
                ov_out = (b_in[7] != a_in[7]) && (sum[7] != b_in[7]);
            end
            3'd2:    res = a_in & b_in;
            3'd3:    res = a_in | b_in;
            3'd4:    res = a_in ^ b_in;
            default: res = b_in;
        endcase
    end
endmodule

// ===== verilog/idcp_core.v
`timescale 1ns/1ps
`include "idcp_defs.vh"
module idcp_core
#(
    parameter HAS_EXT_OPS = 1
)
(
    input  wire         core_clk,
    input  wire         rst_n,
    input  wire [2:0]   processor_mode_field,
    input  wire         protect_programmed,
    input  wire         fetch_internal,
    input  wire         tblptr_internal,
    input  wire         interrupt_event,
    input  wire [15:0]  instr,
    input  wire         instr_valid,
    input  wire [7:0]   file_rd_data,
    input  wire [7:0]   pc_latch_high,
    output reg  [7:0]   file_addr_q,
    output reg  [7:0]   file_wr_data_q,
    output reg          file_wr_q,
    output reg  [7:0]   working_register_q,
    output reg  [7:0]   bank_select_register_q,
    output reg          zero_flag_q,
    output reg          carry_flag_q,
    output reg          digit_carry_flag_q,
    output reg          overflow_flag_q,
    output reg          timeout_flag_q,
    output reg          powerdown_flag_q,
    output reg          global_interrupt_disable_q,
    output reg          watchdog_clear_q,
    output reg          sleep_req_q,
    output reg          pc_load_q,
    output reg  [15:0]  pc_target_q,
    output reg          push_q,
    output reg          pop_q,
    output reg          table_read_q,
    output reg          table_write_q,
    output reg          table_latch_rd_q,
    output reg          table_latch_wr_q,
    output reg          table_blocked_q,
    output reg          programming_q,
    output wire         readout_allowed,
    output wire         busy
);
    // ----------------------------------------------------------------
    // protection
    // ----------------------------------------------------------------
    wire protected_mode;
    wire table_ok;
    assign protected_mode = (processor_mode_field == `IDCP_MODE_PROTECTED);
    assign table_ok = !protected_mode || fetch_internal;
    assign readout_allowed = !protect_programmed;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire [7:0] hi = instr[15:8];
    wire [7:0] lo = instr[7:0];
    wire [2:0] bidx = instr[10:8];
    wire [7:0] bmask = 8'h01 << bidx;
    reg  [1:0] cyc_left_q;
    reg        squash_q;
    wire       accept = instr_valid && (cyc_left_q == 2'd0) && !programming_q;
    wire       exec = accept && !squash_q;
    assign busy = (cyc_left_q != 2'd0) || programming_q;

    wire is_tblwt = (hi[7:2] == `IDCP_OP_TBLWT_HI);
    wire is_tblrd = (hi[7:2] == `IDCP_OP_TBLRD_HI);
    wire is_table_latch_read_op  = (hi[7:2] == `IDCP_OP_TABLE_LATCH_READ_OP_HI);
    wire is_table_latch_write_op  = (hi[7:2] == `IDCP_OP_TABLE_LATCH_WRITE_OP_HI);
    wire is_tstz  = (hi == `IDCP_OP_TSTZ);
    wire is_xorf  = (hi[7:1] == `IDCP_OP_XORF_HI);
    wire is_bclr  = (hi[7:3] == `IDCP_OP_BCLR_HI);
    wire is_bset  = (hi[7:3] == `IDCP_OP_BSET_HI);
    wire is_skclr = (hi[7:3] == `IDCP_OP_SKCLR_HI);
    wire is_skset = (hi[7:3] == `IDCP_OP_SKSET_HI);
    wire is_btog  = (hi[7:3] == `IDCP_OP_BTOG_HI);
    wire is_movr  = (hi[7:1] == `IDCP_OP_MOVR_HI) && (HAS_EXT_OPS != 0);
    wire is_mull  = (hi == `IDCP_OP_MULL) && (HAS_EXT_OPS != 0);
    wire is_goto  = (instr[15:13] == `IDCP_OP_GOTO_HI);
    wire is_call  = (instr[15:13] == `IDCP_OP_CALL_HI);
    wire is_lit_alu = (hi >= `IDCP_OP_ADDL) && (hi <= `IDCP_OP_ANDL);
    wire [15:0] mul = working_register_q * lo;

    wire skip_now = (is_tstz && (file_rd_data == 8'h00)) ||
                    (is_skclr && ((file_rd_data & bmask) == 8'h00)) ||
                    (is_skset && ((file_rd_data & bmask) != 8'h00));

    // literal alu select
    reg [2:0] alu_sel;
    always @*
    begin
        case (hi)
            `IDCP_OP_ADDL: alu_sel = 3'd0;
            `IDCP_OP_SUBL: alu_sel = 3'd1;
            `IDCP_OP_ANDL: alu_sel = 3'd2;
            `IDCP_OP_IORL: alu_sel = 3'd3;
            `IDCP_OP_XORL: alu_sel = 3'd4;
            default:       alu_sel = is_xorf ? 3'd4 : 3'd7;
        endcase
    end
    wire [7:0] alu_b = is_xorf ? file_rd_data : lo;
    wire [7:0] alu_res;
    wire       alu_c;
    wire       alu_dc;
    wire       alu_ov;
    idcp_alu u_alu
    (
        .op_sel (alu_sel),
        .a_in   (working_register_q),
        .b_in   (alu_b),
        .res    (alu_res),
        .c_out  (alu_c),
        .dc_out (alu_dc),
        .ov_out (alu_ov)
    );

    // cycles beyond the first
    reg [1:0] extra;
    always @*
    begin
        extra = 2'd0;
        if (is_goto || is_call || hi == `IDCP_OP_LONG_CALL_OP || hi == `IDCP_OP_RETL ||
            instr == `IDCP_OP_RETURN || instr == `IDCP_OP_INTERRUPT_RETURN_OP)
            extra = `IDCP_CYC_TWO - 2'd1;
        if (is_tblwt || is_tblrd)
            extra = `IDCP_CYC_TWO - 2'd1;
        if (is_tblrd && lo == `IDCP_PCL_ADDR)
            extra = `IDCP_CYC_THREE - 2'd1;
    end

    // ----------------------------------------------------------------
    // execute
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc_left_q                 <= 2'd0;
            squash_q                   <= 1'b0;
            file_addr_q                <= 8'h00;
            file_wr_data_q             <= 8'h00;
            file_wr_q                  <= 1'b0;
            working_register_q         <= 8'h00;
            bank_select_register_q     <= 8'h00;
            zero_flag_q                <= 1'b0;
            carry_flag_q               <= 1'b0;
            digit_carry_flag_q         <= 1'b0;
            overflow_flag_q            <= 1'b0;
            timeout_flag_q             <= 1'b1;
            powerdown_flag_q           <= 1'b1;
            global_interrupt_disable_q <= 1'b1;
            watchdog_clear_q           <= 1'b0;
            sleep_req_q                <= 1'b0;
            pc_load_q                  <= 1'b0;
            pc_target_q                <= 16'h0000;
            push_q                     <= 1'b0;
            pop_q                      <= 1'b0;
            table_read_q               <= 1'b0;
            table_write_q              <= 1'b0;
            table_latch_rd_q           <= 1'b0;
            table_latch_wr_q           <= 1'b0;
            table_blocked_q            <= 1'b0;
            programming_q              <= 1'b0;
        end
        else
        begin
            file_wr_q        <= 1'b0;
            watchdog_clear_q <= 1'b0;
            sleep_req_q      <= 1'b0;
            pc_load_q        <= 1'b0;
            push_q           <= 1'b0;
            pop_q            <= 1'b0;
            table_read_q     <= 1'b0;
            table_write_q    <= 1'b0;
            table_latch_rd_q <= 1'b0;
            table_latch_wr_q <= 1'b0;
            table_blocked_q  <= 1'b0;
            if (cyc_left_q != 2'd0)
                cyc_left_q <= cyc_left_q - 2'd1;
            if (programming_q && interrupt_event)
                programming_q <= 1'b0;
            if (accept)
            begin
                squash_q <= 1'b0;
                file_addr_q <= lo;
            end
            if (exec)
            begin
                cyc_left_q <= extra;
                squash_q <= skip_now;
                if (is_bclr)
                begin
                    file_wr_data_q <= file_rd_data & ~bmask;
                    file_wr_q      <= 1'b1;
                end
                if (is_bset || is_btog)
                begin
                    file_wr_data_q <= is_bset ? (file_rd_data | bmask) : (file_rd_data ^ bmask);
                    file_wr_q      <= 1'b1;
                end
                if (is_xorf)
                begin
                    zero_flag_q <= (alu_res == 8'h00);
                    if (instr[8])
                    begin
                        file_wr_data_q <= alu_res;
                        file_wr_q      <= 1'b1;
                    end
                    else
                        working_register_q <= alu_res;
                end
                if (is_lit_alu)
                begin
                    working_register_q <= alu_res;
                    zero_flag_q        <= (alu_res == 8'h00);
                end
                if (hi == `IDCP_OP_ADDL || hi == `IDCP_OP_SUBL)
                begin
                    carry_flag_q       <= alu_c;
                    digit_carry_flag_q <= alu_dc;
                    overflow_flag_q    <= alu_ov;
                end
                if (hi == `IDCP_OP_MOVL)
                    working_register_q <= lo;
                if (is_mull)
                    working_register_q <= mul[7:0];
                if (hi == `IDCP_OP_MOVB)
                    bank_select_register_q[3:0] <= lo[3:0];
                if (is_movr)
                    bank_select_register_q[7:4] <= lo[7:4];
                if (is_goto || is_call)
                begin
                    pc_load_q   <= 1'b1;
                    pc_target_q <= {3'b000, instr[12:0]};
                    push_q      <= is_call;
                end
                if (hi == `IDCP_OP_LONG_CALL_OP)
                begin
                    pc_load_q   <= 1'b1;
                    pc_target_q <= {pc_latch_high, lo};
                    push_q      <= 1'b1;
                end
                if (hi == `IDCP_OP_RETL || instr == `IDCP_OP_RETURN ||
                    instr == `IDCP_OP_INTERRUPT_RETURN_OP)
                    pop_q <= 1'b1;
                if (hi == `IDCP_OP_RETL)
                    working_register_q <= lo;
                if (instr == `IDCP_OP_INTERRUPT_RETURN_OP)
                    global_interrupt_disable_q <= 1'b0;
                if (instr == `IDCP_OP_WATCHDOG_CLEAR_OP)
                begin
                    watchdog_clear_q <= 1'b1;
                    timeout_flag_q   <= 1'b1;
                    powerdown_flag_q <= 1'b1;
                end
                if (instr == `IDCP_OP_SLEEP)
                begin
                    sleep_req_q      <= 1'b1;
                    timeout_flag_q   <= 1'b1;
                    powerdown_flag_q <= 1'b0;
                end
                if (is_tblwt || is_tblrd)
                begin
                    table_blocked_q <= !table_ok;
                    table_write_q   <= is_tblwt && table_ok;
                    table_read_q    <= is_tblrd && table_ok;
                    programming_q   <= is_tblwt && table_ok && tblptr_internal;
                end
                table_latch_rd_q <= is_table_latch_read_op;
                table_latch_wr_q <= is_table_latch_write_op;
            end
        end
    end
endmodule

// ===== testbench/idcp_core_monitor.sv
`timescale 1ns/1ps
module idcp_core_monitor
(
    input wire        core_clk,
    input wire        rst_n,
    input wire [2:0]  processor_mode_field,
    input wire        protect_programmed,
    input wire        fetch_internal,
    input wire        interrupt_event,
    input wire [15:0] instr,
    input wire        instr_valid,
    input wire [7:0]  pc_latch_high,
    input wire [7:0]  working_register_q,
    input wire [7:0]  bank_select_register_q,
    input wire        global_interrupt_disable_q,
    input wire        pc_load_q,
    input wire [15:0] pc_target_q,
    input wire        push_q,
    input wire        table_read_q,
    input wire        table_write_q,
    input wire        table_blocked_q,
    input wire        programming_q,
    input wire        readout_allowed,
    input wire        busy
);
    // ----------------------------------------------------------------
    // helpers and properties
    // ----------------------------------------------------------------
    reg  skip_q;
    wire take = instr_valid && !busy;
    wire acc  = take && !skip_q;
    wire tbl  = instr[15:11] == 5'b10101;
    wire lock = processor_mode_field == 3'b000 && !fetch_internal;
    // marks the slot after a skip-type op taken outside a marked slot, which may be squashed
    always @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            skip_q <= 1'b0;
        else if (take)
            skip_q <= !skip_q && (instr[15:12] == 4'h9 || instr[15:8] == 8'h33);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_two;
        busy ##1 !busy;
    endsequence
    sequence s_three;
        busy ##1 busy ##1 !busy;
    endsequence
    property p_block;
        acc && tbl && lock |=> table_blocked_q && !table_read_q && !table_write_q;
    endproperty
    a_block: assert property (p_block) else $error("table access not blocked");
    property p_inside;
        acc && tbl && !lock |=> !table_blocked_q;
    endproperty
    a_inside: assert property (p_inside) else $error("table access wrongly blocked");
    property p_readout;
        readout_allowed == !protect_programmed;
    endproperty
    a_readout: assert property (p_readout) else $error("readout gate wrong");
    property p_prog;
        programming_q && interrupt_event |=> !programming_q;
    endproperty
    a_prog: assert property (p_prog) else $error("programming not ended");
    property p_goto;
        acc && instr[15:13] == 3'b110 |=> pc_load_q && pc_target_q[12:0] == $past(instr[12:0])
            ##0 s_two;
    endproperty
    a_goto: assert property (p_goto) else $error("branch target or length wrong");
    property p_long_call_op;
        acc && instr[15:8] == 8'hb7 |=> push_q
            && pc_target_q == {$past(pc_latch_high), $past(instr[7:0])};
    endproperty
    a_long_call_op: assert property (p_long_call_op) else $error("long call target wrong");
    property p_bank;
        acc && instr[15:8] == 8'hb8 |=> bank_select_register_q[3:0] == $past(instr[3:0])
            && bank_select_register_q[7:4] == $past(bank_select_register_q[7:4]);
    endproperty
    a_bank: assert property (p_bank) else $error("low bank nibble wrong");
    property p_movl;
        acc && instr[15:8] == 8'hb0 |=> working_register_q == $past(instr[7:0]);
    endproperty
    a_movl: assert property (p_movl) else $error("literal load wrong");
    property p_interrupt_return_op;
        acc && instr == 16'h0005 |=> !global_interrupt_disable_q;
    endproperty
    a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("interrupts not enabled");
    property p_tblrd;
        acc && instr[15:10] == 6'b101010 && instr[7:0] == 8'h02 && !lock |=> s_three;
    endproperty
    a_tblrd: assert property (p_tblrd) else $error("pc low table read length");
endmodule
bind idcp_core idcp_core_monitor idcp_core_monitor_inst (.core_clk(core_clk), .rst_n(rst_n),
    .processor_mode_field(processor_mode_field), .protect_programmed(protect_programmed),
    .fetch_internal(fetch_internal), .interrupt_event(interrupt_event), .instr(instr),
    .instr_valid(instr_valid), .pc_latch_high(pc_latch_high), .pc_load_q(pc_load_q),
    .working_register_q(working_register_q), .bank_select_register_q(bank_select_register_q),
    .global_interrupt_disable_q(global_interrupt_disable_q), .pc_target_q(pc_target_q),
    .push_q(push_q), .table_read_q(table_read_q), .table_write_q(table_write_q),
    .table_blocked_q(table_blocked_q), .programming_q(programming_q),
    .readout_allowed(readout_allowed), .busy(busy));

// ===== testbench/idcp_file_model.sv
`timescale 1ns/1ps
module idcp_file_model
(
    input  wire       core_clk,
    input  wire [7:0] rd_addr,
    output wire [7:0] rd_data,
    input  wire       wr,
    input  wire [7:0] wr_addr,
    input  wire [7:0] wr_data
);
    reg [7:0] mem [0:255];
    integer   i;
    // file space starts cleared
    initial
    begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = 8'h00;
    end
    // same-cycle read, write lands on the next edge
    assign rd_data = mem[rd_addr];
    always @(posedge core_clk)
        if (wr)
            mem[wr_addr] <= wr_data;
endmodule

// ===== testbench/idcp_core_test.sv
`timescale 1ns/1ps
module idcp_core_test;
    reg         core_clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [2:0]  mode = 3'b010;
    reg         prot = 1'b1;
    reg         fint = 1'b0;
    reg         tint = 1'b0;
    reg         irq = 1'b0;
    reg  [15:0] instr = 16'h0000;
    reg         instr_valid = 1'b0;
    reg  [7:0]  pclh = 8'h00;
    wire [7:0]  rdat, faddr, fdata, w, bank_select_register;
    wire [15:0] pct;
    wire        fwr, z, c, dc, ov, to, pd, gid, wdc, slp, pc_low_byte, push, pop;
    wire        trd, twr, tlr, tlw, tblk, prog, rdo, busy;
    integer     miscompares = 0;
    integer     num_checks = 0;
    integer     cyc = 0;
    idcp_core idcp_core_inst (.core_clk(core_clk), .rst_n(rst_n), .processor_mode_field(mode),
        .protect_programmed(prot), .fetch_internal(fint), .tblptr_internal(tint),
        .interrupt_event(irq), .instr(instr), .instr_valid(instr_valid), .file_rd_data(rdat),
        .pc_latch_high(pclh), .file_addr_q(faddr), .file_wr_data_q(fdata), .file_wr_q(fwr),
        .working_register_q(w), .bank_select_register_q(bank_select_register), .zero_flag_q(z),
        .carry_flag_q(c), .digit_carry_flag_q(dc), .overflow_flag_q(ov), .timeout_flag_q(to),
        .powerdown_flag_q(pd), .global_interrupt_disable_q(gid), .watchdog_clear_q(wdc),
        .sleep_req_q(slp), .pc_load_q(pc_low_byte), .pc_target_q(pct), .push_q(push), .pop_q(pop),
        .table_read_q(trd), .table_write_q(twr), .table_latch_rd_q(tlr),
        .table_latch_wr_q(tlw), .table_blocked_q(tblk), .programming_q(prog),
        .readout_allowed(rdo), .busy(busy));
    idcp_file_model idcp_file_model_inst (.core_clk(core_clk), .rd_addr(instr[7:0]),
        .rd_data(rdat), .wr(fwr), .wr_addr(faddr), .wr_data(fdata));
    // ----------------------------------------------------------------
    // clock, timeout, tasks
    // ----------------------------------------------------------------
    always #10 core_clk = ~core_clk;
    // hang guard
    always @(posedge core_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end
    task give_verdict;
    begin
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task chk1(input g, input e);
    begin
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t bit %b want %b", $time, g, e);
        end
    end
    endtask
    task chk8(input [7:0] g, input [7:0] e);
    begin
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t byte %h want %h", $time, g, e);
        end
    end
    endtask
    // offers one instruction once the core is free, returns after its edge
    task exec(input [15:0] i);
        integer n;
    begin
        n = 0;
        while (busy !== 1'b0 && n < 50)
        begin
            @(negedge core_clk);
            n = n + 1;
        end
        instr = i;
        instr_valid = 1'b1;
        @(negedge core_clk);
    end
    endtask
    task idle(input integer n);
    begin
        instr_valid = 1'b0;
        repeat (n) @(negedge core_clk);
    end
    endtask
    task lit(input [7:0] op, input [7:0] wi, input [7:0] k, input [7:0] r, input zf);
    begin
        exec({8'hb0, wi});
        exec({op, k});
        chk8(w, r);
        chk1(z, zf);
    end
    endtask
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        chk1(rdo, 1'b0);
        prot = 1'b0;
        #1 chk1(rdo, 1'b1);
        @(negedge core_clk);
        lit(8'hb5, 8'hf0, 8'h0f, 8'h00, 1'b1);
        lit(8'hb3, 8'hf0, 8'h0f, 8'hff, 1'b0);
        lit(8'hb4, 8'hf0, 8'hf0, 8'h00, 1'b1);
        lit(8'hb2, 8'h05, 8'h05, 8'h00, 1'b1);
        lit(8'hb1, 8'hff, 8'h01, 8'h00, 1'b1);
        chk1(c, 1'b1);
        chk1(dc, 1'b1);
        chk1(ov, 1'b0);
        lit(8'hbc, 8'h03, 8'h04, 8'h0c, 1'b1);
        exec(16'hb8f5);
        exec(16'hbaa0);
        chk8(bank_select_register, 8'ha5);
        exec(16'hb803);
        chk8(bank_select_register, 8'ha3);
        exec(16'h8721);
        chk1(fwr, 1'b1);
        chk8(fdata, 8'h80);
        idle(1);
        exec(16'hb011);
        exec(16'h9721);
        exec(16'hb099);
        chk8(w, 8'h11);
        exec(16'h9f21);
        exec(16'hb066);
        chk8(w, 8'h66);
        exec(16'h3322);
        exec(16'hb0aa);
        chk8(w, 8'h66);
        exec(16'h0c21);
        chk8(w, 8'he6);
        exec(16'h0d21);
        chk8(fdata, 8'h66);
        idle(1);
        exec(16'h3f21);
        chk8(fdata, 8'he6);
        exec(16'h8f21);
        chk1(fwr, 1'b1);
        exec(16'hd234);
        chk1(pc_low_byte, 1'b1);
        chk8({3'b000, pct[12:8]}, 8'h12);
        exec(16'he055);
        chk1(push, 1'b1);
        pclh = 8'h5a;
        exec(16'hb742);
        chk8(pct[15:8], 8'h5a);
        chk8(pct[7:0], 8'h42);
        exec(16'h0005);
        chk1(gid, 1'b0);
        exec(16'hb677);
        chk8(w, 8'h77);
        chk1(pop, 1'b1);
        exec(16'h0003);
        chk1(pd, 1'b0);
        chk1(to, 1'b1);
        chk1(slp, 1'b1);
        exec(16'h0004);
        chk1(pd, 1'b1);
        chk1(wdc, 1'b1);
        mode = 3'b000;
        exec(16'ha830);
        chk1(tblk, 1'b1);
        chk1(trd, 1'b0);
        fint = 1'b1;
        exec(16'ha830);
        chk1(trd, 1'b1);
        chk1(tblk, 1'b0);
        exec(16'ha430);
        chk1(tlw, 1'b1);
        exec(16'ha030);
        chk1(tlr, 1'b1);
        mode = 3'b010;
        exec(16'hac30);
        chk1(twr, 1'b1);
        chk1(busy, 1'b1);
        idle(1);
        chk1(busy, 1'b0);
        exec(16'ha802);
        chk1(trd, 1'b1);
        idle(1);
        chk1(busy, 1'b1);
        idle(1);
        chk1(busy, 1'b0);
        tint = 1'b1;
        exec(16'hac30);
        idle(5);
        chk1(prog, 1'b1);
        irq = 1'b1;
        @(negedge core_clk);
        irq = 1'b0;
        chk1(prog, 1'b0);
        idle(2);
        give_verdict;
    end
endmodule
